// file: hw/tcf_pkg.sv
// Constants and types for the transmit control and FIFO sizing bank.
// Assumes a 32-bit word register port with byte offsets.
package tcf_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_TX_CTRL = 8'h70;
    localparam logic [7:0] OFF_HARDWARE_CONFIGURATION = 8'h74;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_STOP = 0;
    localparam int BIT_ON = 1;
    localparam int BIT_PERMIT = 2;
    localparam int BIT_FLUSH_DATA = 14;
    localparam int BIT_FLUSH_STAT = 15;
    localparam int BIT_THR_LO = 12;
    localparam int BIT_ALLOC_LO = 16;
    localparam int BIT_SF = 20;
    localparam int BIT_TTS = 21;

    // ----------------------------------------
    // Reset values and sizes
    // ----------------------------------------
    localparam logic [3:0] ALLOC_RST = 4'h5;
    localparam logic [4:0] TOTAL_KB = 5'h10;
    localparam logic [11:0] WORDS_PER_KB = 12'h100;
    localparam logic [11:0] STAT_WORDS = 12'h080;
    localparam int RST_SYNC_STAGES = 2;

    // Start thresholds in words, table 0 then table 1
    localparam logic [8:0] THR_T0 [4] = '{9'h012, 9'h018, 9'h020, 9'h028};
    localparam logic [8:0] THR_T1 [4] = '{9'h020, 9'h040, 9'h080, 9'h100};

    typedef struct packed {
        logic stop;
        logic on;
        logic permit;
        logic tts;
        logic sf;
        logic [3:0] alloc;
        logic [1:0] thr;
    } tcf_cfg_t;

    typedef struct packed {
        logic [11:0] wptr;
        logic [11:0] rptr;
        logic [11:0] lvl;
        logic full;
    } tcf_fifo_t;

    typedef struct packed {
        tcf_cfg_t cfg;
        tcf_fifo_t dat;
        tcf_fifo_t sts;
        logic [11:0] frames;
        logic busy;
        logic start;
        logic suspend;
        logic [4:0] rx_kb;
        logic [31:0] rdata;
    } tcf_state_t;

endpackage

// file: hw/tcf_top.sv
// Transmit control, graceful stop and TX/RX buffer split of an Ethernet MAC.
// Assumes FIFO push/pop strobes and frame done come from logic on I_CLK.
// I_ARST_N may fall at any time; all state past the release stages runs on the released copy.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps

module tcf_top
    import tcf_pkg::*;
#(
    parameter int AW = 8
) (
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    input wire logic [AW-1:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    input wire logic I_TXD_PUSH,
    input wire logic I_TXD_LAST,
    input wire logic I_TXD_POP,
    input wire logic I_TXS_PUSH,
    input wire logic I_TXS_POP,
    input wire logic I_FRAME_DONE,
    output logic O_TXD_FULL,
    output logic [11:0] O_TXD_LEVEL,
    output logic [11:0] O_TXD_WPTR,
    output logic [11:0] O_TXD_RPTR,
    output logic O_TXS_FULL,
    output logic [11:0] O_TXS_LEVEL,
    output logic [11:0] O_TXS_WPTR,
    output logic [11:0] O_TXS_RPTR,
    output logic O_TX_START,
    output logic O_TX_BUSY,
    output logic O_TX_SUSPEND,
    output logic O_TX_ENABLED,
    output logic [4:0] O_RX_ALLOC_KB
);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    // Decode needs the whole byte offset below the page bits
    if (AW < 8) begin : g_aw_check
        $error("tcf_top: AW must be at least 8");
    end
    // One stage could hand out a release edge that is still metastable
    if (RST_SYNC_STAGES < 2) begin : g_sync_check
        $error("tcf_top: reset release needs at least two stages");
    end

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic [RST_SYNC_STAGES-1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rst_sync_q <= '0;
        end else begin
            rst_sync_q <= {rst_sync_q[RST_SYNC_STAGES-2:0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[RST_SYNC_STAGES-1];

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Data FIFO words: allocation less the 512-byte status share
    function automatic logic [11:0] data_cap(input logic [3:0] alloc);
        logic [11:0] words;
        words = 12'(alloc) * WORDS_PER_KB;
        if (alloc == 4'h0) begin
            data_cap = 12'h000;
        end else begin
            data_cap = words - STAT_WORDS;
        end
    endfunction

    // Pointer advance, wrapping at the capacity in force now
    function automatic logic [11:0] ptr_inc(input logic [11:0] p, input logic [11:0] cap);
        logic [11:0] nxt;
        nxt = p + 12'h001;
        if (nxt >= cap) begin
            ptr_inc = 12'h000;
        end else begin
            ptr_inc = nxt;
        end
    endfunction

    // Register hit: offset matches and every page bit above it is zero
    function automatic logic reg_hit(input logic [AW-1:0] a, input logic [7:0] off);
        reg_hit = (a[7:0] == off) && ((a >> 8) == '0);
    endfunction

    // Start point in words for the early-start mode
    function automatic logic [11:0] start_thr(input logic tts, input logic [1:0] idx);
        if (tts) begin
            start_thr = 12'(THR_T1[idx]);
        end else begin
            start_thr = 12'(THR_T0[idx]);
        end
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    tcf_state_t s_q;
    tcf_state_t s_d;

    logic wr_ctrl;
    logic wr_hw;
    logic flush_dat;
    logic flush_sts;
    logic [11:0] dcap;
    logic dpush;
    logic dpop;
    logic spush;
    logic spop;
    logic ready;

    always_comb begin
        s_d = s_q;
        wr_ctrl = I_WR && reg_hit(I_ADDR, OFF_TX_CTRL);
        wr_hw = I_WR && reg_hit(I_ADDR, OFF_HARDWARE_CONFIGURATION);
        flush_sts = wr_ctrl && I_WDATA[BIT_FLUSH_STAT];
        flush_dat = wr_ctrl && I_WDATA[BIT_FLUSH_DATA];
        dcap = data_cap(s_q.cfg.alloc);
        s_d.start = 1'b0;

        // ----------------------------------------
        // Register read
        // ----------------------------------------
        // Read data valid only in the cycle after the strobe
        s_d.rdata = 32'h0000_0000;
        if (I_RD) begin
            if (reg_hit(I_ADDR, OFF_TX_CTRL)) begin
                // Flush bits self-clear, so they always read zero
                s_d.rdata[BIT_PERMIT] = s_q.cfg.permit;
                s_d.rdata[BIT_ON] = s_q.cfg.on;
                s_d.rdata[BIT_STOP] = s_q.cfg.stop;
            end else if (reg_hit(I_ADDR, OFF_HARDWARE_CONFIGURATION)) begin
                s_d.rdata[BIT_TTS] = s_q.cfg.tts;
                s_d.rdata[BIT_SF] = s_q.cfg.sf;
                s_d.rdata[BIT_ALLOC_LO +: 4] = s_q.cfg.alloc;
                s_d.rdata[BIT_THR_LO +: 2] = s_q.cfg.thr;
            end
        end

        // ----------------------------------------
        // Register write
        // ----------------------------------------
        if (wr_ctrl) begin
            s_d.cfg.permit = I_WDATA[BIT_PERMIT];
            s_d.cfg.on = I_WDATA[BIT_ON];
            // Stop is sticky: a zero cannot cancel a pending halt
            if (!s_q.cfg.stop) begin
                s_d.cfg.stop = I_WDATA[BIT_STOP];
            end
        end
        if (wr_hw) begin
            s_d.cfg.tts = I_WDATA[BIT_TTS];
            s_d.cfg.sf = I_WDATA[BIT_SF];
            s_d.cfg.alloc = I_WDATA[BIT_ALLOC_LO +: 4];
            s_d.cfg.thr = I_WDATA[BIT_THR_LO +: 2];
        end

        // ----------------------------------------
        // Data FIFO: commands and payload share one queue
        // ----------------------------------------
        dpush = I_TXD_PUSH && !s_q.dat.full;
        dpop = I_TXD_POP && (s_q.dat.lvl != 12'h000);
        if (dpush) begin
            s_d.dat.wptr = ptr_inc(s_q.dat.wptr, dcap);
        end
        if (dpop) begin
            s_d.dat.rptr = ptr_inc(s_q.dat.rptr, dcap);
        end
        if (dpush && !dpop) begin
            s_d.dat.lvl = s_q.dat.lvl + 12'h001;
        end else if (dpop && !dpush) begin
            s_d.dat.lvl = s_q.dat.lvl - 12'h001;
        end
        if (dpush && I_TXD_LAST) begin
            s_d.frames = s_q.frames + 12'h001;
        end

        // ----------------------------------------
        // Status FIFO, fixed 512 bytes
        // ----------------------------------------
        spush = I_TXS_PUSH && !s_q.sts.full;
        spop = I_TXS_POP && (s_q.sts.lvl != 12'h000);
        if (spush) begin
            s_d.sts.wptr = ptr_inc(s_q.sts.wptr, STAT_WORDS);
        end
        if (spop) begin
            s_d.sts.rptr = ptr_inc(s_q.sts.rptr, STAT_WORDS);
        end
        if (spush && !spop) begin
            s_d.sts.lvl = s_q.sts.lvl + 12'h001;
        end else if (spop && !spush) begin
            s_d.sts.lvl = s_q.sts.lvl - 12'h001;
        end

        // ----------------------------------------
        // Transmit sequencing
        // ----------------------------------------
        // Store-forward ignores table select and threshold field
        if (s_q.cfg.sf) begin
            ready = s_q.frames != 12'h000;
        end else begin
            ready = (s_q.frames != 12'h000) ||
                (s_q.dat.lvl >= start_thr(s_q.cfg.tts, s_q.cfg.thr));
        end
        // Underrun is the host's problem; frame done still ends the frame
        if (s_q.busy) begin
            if (I_FRAME_DONE) begin
                s_d.busy = 1'b0;
            end
        end else if (s_q.cfg.on && !s_q.cfg.stop && !s_q.suspend && ready) begin
            s_d.start = 1'b1;
            s_d.busy = 1'b1;
            if (s_q.frames != 12'h000) begin
                s_d.frames = s_d.frames - 12'h001;
            end
        end
        // Halt only between frames, so the frame in flight completes
        if (s_q.cfg.stop && !s_q.busy) begin
            s_d.cfg.stop = 1'b0;
            s_d.cfg.on = 1'b0;
        end

        // Flush beats a push in the same cycle
        if (flush_dat) begin
            s_d.dat = '0;
            s_d.frames = 12'h000;
        end
        if (flush_sts) begin
            s_d.sts = '0;
        end

        // ----------------------------------------
        // Fill flags and derived values
        // ----------------------------------------
        // Against the new allocation, so a shrink to a capacity at or below the current level reads full
        s_d.dat.full = s_d.dat.lvl >= data_cap(s_d.cfg.alloc);
        s_d.sts.full = s_d.sts.lvl >= STAT_WORDS;
        s_d.suspend = s_d.sts.full && !s_d.cfg.permit;
        s_d.rx_kb = TOTAL_KB - 5'(s_d.cfg.alloc);
    end

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.cfg.alloc <= ALLOC_RST;
            s_q.dat.full <= 1'b0;
            s_q.rx_kb <= TOTAL_KB - 5'(ALLOC_RST);
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign O_RDATA = s_q.rdata;
    assign O_TXD_FULL = s_q.dat.full;
    assign O_TXD_LEVEL = s_q.dat.lvl;
    assign O_TXD_WPTR = s_q.dat.wptr;
    assign O_TXD_RPTR = s_q.dat.rptr;
    assign O_TXS_FULL = s_q.sts.full;
    assign O_TXS_LEVEL = s_q.sts.lvl;
    assign O_TXS_WPTR = s_q.sts.wptr;
    assign O_TXS_RPTR = s_q.sts.rptr;
    assign O_TX_START = s_q.start;
    assign O_TX_BUSY = s_q.busy;
    assign O_TX_SUSPEND = s_q.suspend;
    assign O_TX_ENABLED = s_q.cfg.on;
    assign O_RX_ALLOC_KB = s_q.rx_kb;

endmodule

// file: test/tcf_top_checker.sv
// Port checker for tcf_top: register port, flushes, transmit start.
// Assumes it is bound into tcf_top and sees only its ports.
`timescale 1ns/1ps
module tcf_top_checker
    import tcf_pkg::*;
#(
    parameter int AW = 8
) (
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    input wire logic [AW-1:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [31:0] O_RDATA,
    input wire logic I_FRAME_DONE,
    input wire logic [11:0] O_TXD_LEVEL,
    input wire logic [11:0] O_TXS_LEVEL,
    input wire logic O_TX_START,
    input wire logic O_TX_BUSY,
    input wire logic O_TX_SUSPEND,
    input wire logic O_TX_ENABLED,
    input wire logic [4:0] O_RX_ALLOC_KB
);
    // ----------------------------------------
    // Decode and properties
    // ----------------------------------------
    logic ctl_w, hw_w, ctl_r;
    logic [3:0] alloc_w;
    assign ctl_w = I_WR && I_ADDR == AW'(OFF_TX_CTRL);
    assign hw_w = I_WR && I_ADDR == AW'(OFF_HARDWARE_CONFIGURATION);
    assign ctl_r = I_RD && I_ADDR == AW'(OFF_TX_CTRL);
    assign alloc_w = I_WDATA[19:16];
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);

    rdata_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
        else $error("read data not zero outside the read slot");
    ctl_rsvd_a: assert property (ctl_r |=> O_RDATA[31:3] == 29'h0)
        else $error("transmit control reads back a one in a zero bit");
    sts_flush_a: assert property (ctl_w && I_WDATA[15] |-> ##[1:2] O_TXS_LEVEL == 12'h0)
        else $error("status queue not emptied by flush");
    dat_flush_a: assert property (ctl_w && I_WDATA[14] |-> ##[1:2] O_TXD_LEVEL == 12'h0)
        else $error("data queue not emptied by flush");
    susp_hold_a: assert property (O_TX_SUSPEND [*2] |-> !O_TX_START)
        else $error("frame started while suspended");
    start_pulse_a: assert property (O_TX_START |-> O_TX_BUSY ##1 !O_TX_START)
        else $error("start pulse malformed");
    busy_end_a: assert property (O_TX_BUSY && I_FRAME_DONE |=> !O_TX_BUSY)
        else $error("busy held after frame done");
    start_en_a: assert property (O_TX_START |-> $past(O_TX_ENABLED))
        else $error("frame started while disabled");
    rx_alloc_a: assert property (hw_w |-> ##2 O_RX_ALLOC_KB == 5'h10 - {1'b0, $past(alloc_w, 2)})
        else $error("receive share wrong after allocation write");

    cover property (O_TX_SUSPEND);
    cover property (O_TX_START);
    cover property ($fell(O_TX_BUSY));
endmodule

// file: test/tcf_line_model.sv
// Line-side partner: ends each started frame, files one status word.
// Assumes the start pulse of tcf_top on the same clock.
`timescale 1ns/1ps
module tcf_line_model #(
    parameter int LAT = 20
) (
    input wire logic i_clk,
    input wire logic i_start,
    output logic o_done,
    output logic o_sts_push
);
    int cnt = 0;
    // Combinational so both outputs are defined from time zero
    assign o_done = (cnt == 1);
    assign o_sts_push = o_done;
    always @(posedge i_clk) begin
        if (i_start) begin
            cnt <= LAT;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// file: test/tcf_top_tb.sv
// Self-checking bench for tcf_top with a line-side partner.
// Assumes a 100 MHz clock and the host register port of tcf_top.
`timescale 1ns/1ps
module tcf_top_tb
    import tcf_pkg::*;
();
    logic clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic tpush = 1'b0, tlast = 1'b0, spush = 1'b0, tpop = 1'b0, spop = 1'b0;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic txd_full, txs_full, start, busy, susp, done, m_sp;
    logic [11:0] txd_lvl, txs_lvl, txd_wp, txd_rp, txs_wp, txs_rp;
    logic [4:0] rx_kb;
    int err_count = 0, n_tests = 0;
    always #5 clk = ~clk;

    tcf_top #(.AW(8)) i_tcf_top (.I_CLK(clk), .I_ARST_N(arst_n), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_TXD_PUSH(tpush),
        .I_TXD_LAST(tlast), .I_TXD_POP(tpop), .I_TXS_PUSH(spush | m_sp),
        .I_TXS_POP(spop), .I_FRAME_DONE(done), .O_TXD_FULL(txd_full),
        .O_TXD_LEVEL(txd_lvl), .O_TXD_WPTR(txd_wp), .O_TXD_RPTR(txd_rp),
        .O_TXS_FULL(txs_full), .O_TXS_LEVEL(txs_lvl), .O_TXS_WPTR(txs_wp),
        .O_TXS_RPTR(txs_rp), .O_TX_START(start),
        .O_TX_BUSY(busy), .O_TX_SUSPEND(susp), .O_TX_ENABLED(), .O_RX_ALLOC_KB(rx_kb));
    tcf_line_model #(.LAT(20)) i_tcf_line_model (.i_clk(clk), .i_start(start),
        .o_done(done), .o_sts_push(m_sp));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(nm, rdata, exp);
    endtask
    task automatic push(input int n, input logic last);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            tpush <= 1'b1;
            tlast <= last && (i == n - 1);
        end
        @(posedge clk);
        tpush <= 1'b0;
        tlast <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic idle;
        for (int i = 0; i < 100 && busy !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        chk("idle", busy, 1'b0);
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic report_and_stop;
        $display("Checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop;
    end

    initial begin
        int thr;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk("tx_ctrl", OFF_TX_CTRL, 32'h0);
        rd_chk("hardware_configuration", OFF_HARDWARE_CONFIGURATION, 32'h00050000);
        chk("rx_kb", rx_kb, 32'hb);
        wr_reg(OFF_HARDWARE_CONFIGURATION, 32'hffeeffff);
        rd_chk("hardware_configuration", OFF_HARDWARE_CONFIGURATION, 32'h002e3000);
        chk("rx_kb", rx_kb, 32'h2);
        wr_reg(OFF_TX_CTRL, 32'hffff3ffc);
        rd_chk("tx_ctrl", OFF_TX_CTRL, 32'h4);
        rd_chk("unmapped", 8'h78, 32'h0);
        $display("Test registers done");
        // ----------------------------------------
        // Full status queue with and without overrun permit
        // ----------------------------------------
        wr_reg(OFF_HARDWARE_CONFIGURATION, 32'h00050000);
        wr_reg(OFF_TX_CTRL, 32'h2);
        repeat (128) begin
            @(posedge clk);
            spush <= 1'b1;
        end
        @(posedge clk);
        spush <= 1'b0;
        push(18, 1'b0);
        chk("sts_lvl", txs_lvl, 32'h80);
        chk("sts_full", txs_full, 1'b1);
        chk("susp", susp, 1'b1);
        chk("busy", busy, 1'b0);
        wr_reg(OFF_TX_CTRL, 32'h6);
        repeat (3) @(posedge clk);
        #1 chk("sts_full", txs_full, 1'b1);
        chk("busy", busy, 1'b1);
        // Line side takes two words from each queue
        repeat (2) begin
            @(posedge clk);
            spop <= 1'b1;
            tpop <= 1'b1;
        end
        @(posedge clk);
        spop <= 1'b0;
        tpop <= 1'b0;
        #1 chk("sts_rptr", txs_rp, 32'h2);
        chk("sts_wptr", txs_wp, 32'h0);
        chk("sts_lvl", txs_lvl, 32'h7e);
        chk("txd_rptr", txd_rp, 32'h2);
        chk("txd_wptr", txd_wp, 32'h12);
        chk("txd_lvl", txd_lvl, 32'h10);
        wr_reg(OFF_TX_CTRL, 32'hc000);
        @(posedge clk);
        #1 chk("sts_lvl", txs_lvl, 32'h0);
        chk("txd_lvl", txd_lvl, 32'h0);
        chk("sts_ptr", {txs_wp, txs_rp}, 32'h0);
        chk("txd_ptr", {txd_wp, txd_rp}, 32'h0);
        rd_chk("tx_ctrl", OFF_TX_CTRL, 32'h0);
        idle();
        $display("Test status done");
        // Smallest legal share: 2 units less the status part
        wr_reg(OFF_HARDWARE_CONFIGURATION, 32'h00020000);
        push(383, 1'b0);
        chk("txd_full", txd_full, 1'b0);
        push(2, 1'b0);
        chk("txd_full", txd_full, 1'b1);
        chk("txd_lvl", txd_lvl, 32'h180);
        wr_reg(OFF_TX_CTRL, 32'h4000);
        @(posedge clk);
        #1 chk("txd_lvl", txd_lvl, 32'h0);
        $display("Test capacity done");
        for (int k = 0; k < 8; k++) begin
            thr = k[2] ? THR_T1[k[1:0]] : THR_T0[k[1:0]];
            wr_reg(OFF_HARDWARE_CONFIGURATION, {10'h0, k[2], 1'b0, 4'h5, 2'h0, k[1:0], 12'h0});
            wr_reg(OFF_TX_CTRL, 32'h6);
            push(thr - 1, 1'b0);
            chk("busy", busy, 1'b0);
            push(1, 1'b0);
            chk("busy", busy, 1'b1);
            wr_reg(OFF_TX_CTRL, 32'hc004);
            idle();
        end
        $display("Test thresholds done");
        // Table select and index set on purpose: both must be ignored
        wr_reg(OFF_HARDWARE_CONFIGURATION, 32'h00351000);
        wr_reg(OFF_TX_CTRL, 32'h6);
        push(257, 1'b0);
        chk("busy", busy, 1'b0);
        push(1, 1'b1);
        chk("busy", busy, 1'b1);
        $display("Test store forward done");
        wr_reg(OFF_TX_CTRL, 32'h7);
        rd_chk("tx_ctrl", OFF_TX_CTRL, 32'h7);
        wr_reg(OFF_TX_CTRL, 32'h6);
        rd_chk("tx_ctrl", OFF_TX_CTRL, 32'h7);
        idle();
        rd_chk("tx_ctrl", OFF_TX_CTRL, 32'h4);
        chk("busy", busy, 1'b0);
        $display("Test stop done");
        report_and_stop;
    end
endmodule

bind tcf_top tcf_top_checker #(.AW(AW)) i_tcf_top_checker (.I_CLK, .I_ARST_N, .I_ADDR,
    .I_WDATA, .I_WR, .I_RD, .O_RDATA, .I_FRAME_DONE, .O_TXD_LEVEL, .O_TXS_LEVEL,
    .O_TX_START, .O_TX_BUSY, .O_TX_SUSPEND, .O_TX_ENABLED, .O_RX_ALLOC_KB);
